// ---- cas_pkg.sv ----
// Package for the concentration alarm and span check block.
// Assumes a single 200 MHz system clock and a plain register port.
package cas_pkg;

    // -------------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------------
    localparam logic [7:0] CAS_OFF_CTRL     = 8'h00;
    localparam logic [7:0] CAS_OFF_A1_CFG   = 8'h04;
    localparam logic [7:0] CAS_OFF_A1_SET   = 8'h08;
    localparam logic [7:0] CAS_OFF_A2_CFG   = 8'h0c;
    localparam logic [7:0] CAS_OFF_A2_SET   = 8'h10;
    localparam logic [7:0] CAS_OFF_CONC     = 8'h14;
    localparam logic [7:0] CAS_OFF_SPAN     = 8'h18;
    localparam logic [7:0] CAS_OFF_STATUS   = 8'h1c;
    localparam logic [7:0] CAS_OFF_IRQ_STAT = 8'h20;
    localparam logic [7:0] CAS_OFF_IRQ_MASK = 8'h24;
    localparam logic [7:0] CAS_OFF_CAL      = 8'h28;
    localparam logic [7:0] CAS_OFF_PASSWORD = 8'h2c;

    // -------------------------------------------------------------------
    // Alarm configuration field positions
    // -------------------------------------------------------------------
    localparam int CAS_CFG_HIGH  = 0;
    localparam int CAS_CFG_DEFT  = 1;
    localparam int CAS_CFG_FS    = 2;
    localparam int CAS_CFG_LATCH = 3;
    localparam logic [3:0] CAS_CFG_RESET = 4'h0;

    // Control register fields.
    localparam int CAS_CTRL_PW_EN   = 0;
    localparam int CAS_CTRL_UNLOCK  = 1;
    localparam int CAS_CTRL_STANDBY = 2;

    // Span register fields: bit 0 done strobe, bit 1 bad zero, upper bits sensitivity.
    localparam int CAS_SPAN_ZERO_BAD = 1;

    // Interrupt bit positions.
    localparam int CAS_IRQ_A1   = 0;
    localparam int CAS_IRQ_A2   = 1;
    localparam int CAS_IRQ_SPAN = 2;
    localparam int CAS_IRQ_CELL = 3;
    localparam int CAS_IRQ_W    = 4;

    // -------------------------------------------------------------------
    // Numeric limits (setpoint and concentration in 0.01 ppm units)
    // -------------------------------------------------------------------
    localparam logic [19:0] CAS_SET_MAX  = 20'hf4240;
    // Minimum sensitivity 0.5 uA/ppm expressed in nA/ppm.
    localparam logic [15:0] CAS_SENS_MIN = 16'h01f4;
    localparam logic [31:0] CAS_PASSWORD_DEF = 32'h00001234;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam longint CAS_CLK_HZ      = 200000000;
    localparam longint CAS_MSG_SEC     = 5;
    localparam longint CAS_MSG_CYCLES  = CAS_MSG_SEC * CAS_CLK_HZ;

    typedef enum logic [2:0] {
        CAS_MEASURE = 3'b001,
        CAS_SPANMSG = 3'b010,
        CAS_CELLMSG = 3'b100
    } cas_mode_t;

endpackage : cas_pkg

// ---- cas_alarm_chan.sv ----
// One concentration alarm channel with relay drive.
// Assumes configuration and samples arrive synchronous to the clock.
module cas_alarm_chan
    import cas_pkg::*;
#(
    parameter int CONC_W = 20
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [CONC_W-1:0] conc,
    input  wire logic              conc_valid,
    input  wire logic [CONC_W-1:0] setpoint,
    input  wire logic [3:0]        cfg,
    output logic                   active,
    output logic                   relay,
    output logic                   trip
);
    initial begin
        if (CONC_W < 20) $error("CONC_W too small for setpoint range");
    end

    logic active_r;
    logic active_nxt;
    logic relay_r;
    logic [3:0] cfg_d_r;

    wire cfg_high   = cfg[CAS_CFG_HIGH];
    wire cfg_defeat = cfg[CAS_CFG_DEFT];
    wire cfg_fs     = cfg[CAS_CFG_FS];
    wire cfg_latch  = cfg[CAS_CFG_LATCH];
    wire above      = conc > setpoint;
    wire below      = conc < setpoint;
    wire cond       = cfg_high ? above : below;
    wire defeat_off = cfg_d_r[CAS_CFG_DEFT] & ~cfg_defeat;
    wire latch_on   = ~cfg_d_r[CAS_CFG_LATCH] & cfg_latch;
    wire clr_latch  = defeat_off | latch_on;
    wire fire       = conc_valid & cond & ~cfg_defeat;
    wire hold       = cfg_latch & active_r & ~clr_latch;

    // Non-latched alarms follow the condition on each sample.
    assign active_nxt = cfg_defeat ? 1'b0 :
                        fire       ? 1'b1 :
                        hold       ? 1'b1 :
                        conc_valid ? 1'b0 :
                        (active_r & ~clr_latch & ~(~cfg_latch & ~cond));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_r <= 1'b0;
            relay_r  <= 1'b0;
            cfg_d_r  <= CAS_CFG_RESET;
        end else begin
            active_r <= active_nxt;
            relay_r  <= cfg_fs ? ~active_nxt : active_nxt;
            cfg_d_r  <= cfg;
        end
    end

    assign active = active_r;
    assign relay  = relay_r;
    assign trip   = active_nxt & ~active_r;
endmodule : cas_alarm_chan

// ---- cas_cal_backup.sv ----
// Holds the active calibration words and a copy of the last loaded set for restore.
// Assumes one update request at a time from the span checker.
module cas_cal_backup #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] new_val,
    input  wire logic         restore,
    output logic [W-1:0]      cal_val
);
    logic [W-1:0] cur_r;
    logic [W-1:0] prev_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_r  <= '0;
            prev_r <= '0;
        end else if (load) begin
            prev_r <= new_val;
            cur_r  <= new_val;
        end else if (restore) begin
            cur_r  <= prev_r;
        end
    end

    assign cal_val = cur_r;
endmodule : cas_cal_backup

// ---- cas_conc_alarm_top.sv ----
// Top of the concentration alarm and span check block.
// Assumes software on a plain register port and relays on flop outputs.
//
// What this block does
// - Reject span below 0.5 uA/ppm, restore calibration.
// - Span reject: system alarm; five second message only if it comes while measuring.
// - Keep calibration-fail indicator while measuring.
// - Fail state clears only by standby cycle.
// - Two concentration alarms, one system alarm relay.
// - High alarm trips above setpoint.
// - Low alarm trips below setpoint.
// - Failsafe relay de-energizes when alarm active.
// - Latched alarm holds until explicitly reset.
// - Non-latched alarm clears on returning condition.
// - Defeated alarm never activates.
// - Setpoint range 0.00 to 10,000.00 ppm.
// - Defeat yes-then-no clears latched alarm.
// - Latch no-then-yes clears latched alarm.
// - Password lock blocks alarm configuration writes.
// - Bad zero: system alarm, cell failure shown.
module cas_conc_alarm_top
    import cas_pkg::*;
#(
    parameter longint MSG_CYCLES = CAS_MSG_CYCLES
) (
    input  wire logic        CLK_SYS_IN,
    input  wire logic        ARST_N_IN,
    input  wire logic [7:0]  ADDR_IN,
    input  wire logic [31:0] WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic      [31:0] RDATA_OUT,
    output logic             RELAY_ONE_OUT,
    output logic             RELAY_TWO_OUT,
    output logic             RELAY_SYS_OUT,
    output logic             CAL_FAIL_FLAG_OUT,
    output logic             SPAN_MSG_OUT,
    output logic             CELL_MSG_OUT,
    output logic             IRQ_OUT
);
    import cas_pkg::*;

    initial begin
        if (MSG_CYCLES < 1) $error("MSG_CYCLES must be at least one");
    end

    // -------------------------------------------------------------------
    // Reset synchroniser
    // -------------------------------------------------------------------
    logic rst_s1_r;
    logic rst_n;
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    // -------------------------------------------------------------------
    // Register decode
    // -------------------------------------------------------------------
    logic [2:0]  ctrl_r;
    logic [3:0]  a1_cfg_r;
    logic [3:0]  a2_cfg_r;
    logic [19:0] a1_set_r;
    logic [19:0] a2_set_r;
    logic [19:0] conc_r;
    logic        conc_valid_r;
    logic [31:0] cal_new_r;
    logic [31:0] password_r;
    logic [CAS_IRQ_W-1:0] irq_stat_r;
    logic [CAS_IRQ_W-1:0] irq_stat_nxt;
    logic [CAS_IRQ_W-1:0] irq_mask_r;
    logic        unlocked_r;

    wire wr_ctrl  = WR_IN & (ADDR_IN == CAS_OFF_CTRL);
    wire wr_a1c   = WR_IN & (ADDR_IN == CAS_OFF_A1_CFG);
    wire wr_a1s   = WR_IN & (ADDR_IN == CAS_OFF_A1_SET);
    wire wr_a2c   = WR_IN & (ADDR_IN == CAS_OFF_A2_CFG);
    wire wr_a2s   = WR_IN & (ADDR_IN == CAS_OFF_A2_SET);
    wire wr_conc  = WR_IN & (ADDR_IN == CAS_OFF_CONC);
    wire wr_span  = WR_IN & (ADDR_IN == CAS_OFF_SPAN);
    wire wr_mask  = WR_IN & (ADDR_IN == CAS_OFF_IRQ_MASK);
    wire wr_cal   = WR_IN & (ADDR_IN == CAS_OFF_CAL);
    wire wr_pw    = WR_IN & (ADDR_IN == CAS_OFF_PASSWORD);
    wire rd_irq   = RD_IN & (ADDR_IN == CAS_OFF_IRQ_STAT);

    // Configuration writes pass only when protection is off or unlocked.
    wire cfg_ok   = ~ctrl_r[CAS_CTRL_PW_EN] | unlocked_r;
    wire set_ok   = WDATA_IN <= 32'(CAS_SET_MAX);
    wire pw_match = WDATA_IN == password_r;

    // Standby cycle: rising edge of the standby control bit.
    logic standby_d_r;
    wire  standby_rise = ctrl_r[CAS_CTRL_STANDBY] & ~standby_d_r;

    always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r       <= 3'h0;
            a1_cfg_r     <= CAS_CFG_RESET;
            a2_cfg_r     <= CAS_CFG_RESET;
            a1_set_r     <= 20'h00000;
            a2_set_r     <= 20'h00000;
            conc_r       <= 20'h00000;
            conc_valid_r <= 1'b0;
            cal_new_r    <= 32'h00000000;
            password_r   <= CAS_PASSWORD_DEF;
            irq_mask_r   <= '0;
            unlocked_r   <= 1'b0;
            standby_d_r  <= 1'b0;
        end else begin
            standby_d_r  <= ctrl_r[CAS_CTRL_STANDBY];
            conc_valid_r <= wr_conc;
            if (wr_ctrl) begin
                ctrl_r[CAS_CTRL_STANDBY] <= WDATA_IN[CAS_CTRL_STANDBY];
                if (cfg_ok) begin
                    ctrl_r[CAS_CTRL_PW_EN] <= WDATA_IN[CAS_CTRL_PW_EN];
                end
                if (WDATA_IN[CAS_CTRL_UNLOCK] == 1'b0) begin
                    unlocked_r <= 1'b0;
                end
            end
            if (wr_pw) begin
                if (cfg_ok) begin
                    password_r <= WDATA_IN;
                end else if (pw_match) begin
                    unlocked_r <= 1'b1;
                end
            end
            if (wr_a1c && cfg_ok) begin
                a1_cfg_r <= WDATA_IN[3:0];
            end
            if (wr_a2c && cfg_ok) begin
                a2_cfg_r <= WDATA_IN[3:0];
            end
            if (wr_a1s && cfg_ok && set_ok) begin
                a1_set_r <= WDATA_IN[19:0];
            end
            if (wr_a2s && cfg_ok && set_ok) begin
                a2_set_r <= WDATA_IN[19:0];
            end
            if (wr_conc) begin
                conc_r <= WDATA_IN[19:0];
            end
            if (wr_cal) begin
                cal_new_r <= WDATA_IN;
            end
            if (wr_mask) begin
                irq_mask_r <= WDATA_IN[CAS_IRQ_W-1:0];
            end
        end
    end

    // -------------------------------------------------------------------
    // Concentration alarms
    // -------------------------------------------------------------------
    logic [1:0] al_active;
    logic [1:0] al_relay;
    logic [1:0] al_trip;

    cas_alarm_chan #(.CONC_W(20)) u_conc_alarm_one (
        .clk        (CLK_SYS_IN),
        .rst_n      (rst_n),
        .conc       (conc_r),
        .conc_valid (conc_valid_r),
        .setpoint   (a1_set_r),
        .cfg        (a1_cfg_r),
        .active     (al_active[0]),
        .relay      (al_relay[0]),
        .trip       (al_trip[0])
    );

    cas_alarm_chan #(.CONC_W(20)) u_conc_alarm_two (
        .clk        (CLK_SYS_IN),
        .rst_n      (rst_n),
        .conc       (conc_r),
        .conc_valid (conc_valid_r),
        .setpoint   (a2_set_r),
        .cfg        (a2_cfg_r),
        .active     (al_active[1]),
        .relay      (al_relay[1]),
        .trip       (al_trip[1])
    );

    // -------------------------------------------------------------------
    // Span check and system alarm
    // -------------------------------------------------------------------
    wire        span_done  = wr_span & WDATA_IN[0];
    wire        zero_bad   = wr_span & WDATA_IN[CAS_SPAN_ZERO_BAD];
    wire [15:0] span_sens  = WDATA_IN[31:16];
    wire        span_rej   = span_done & (span_sens < CAS_SENS_MIN);
    wire        span_good  = span_done & ~span_rej;

    logic [31:0] cal_val;
    cas_cal_backup #(.W(32)) u_cal_backup (
        .clk     (CLK_SYS_IN),
        .rst_n   (rst_n),
        .load    (span_good),
        .new_val (cal_new_r),
        .restore (span_rej),
        .cal_val (cal_val)
    );

    cas_mode_t mode_r;
    cas_mode_t mode_nxt;
    logic [31:0] msg_cnt_r;
    logic        cal_fail_r;
    logic        sys_alarm_r;
    logic        cell_fail_r;

    localparam logic [31:0] MSG_LAST = 32'(MSG_CYCLES - 1);
    wire msg_done = msg_cnt_r == MSG_LAST;

    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            CAS_MEASURE: begin
                if (span_rej) begin
                    mode_nxt = CAS_SPANMSG;
                end else if (zero_bad) begin
                    mode_nxt = CAS_CELLMSG;
                end
            end
            CAS_SPANMSG, CAS_CELLMSG: begin
                if (msg_done) begin
                    mode_nxt = CAS_MEASURE;
                end
            end
            default: mode_nxt = CAS_MEASURE;
        endcase
    end

    always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
        if (!rst_n) begin
            mode_r      <= CAS_MEASURE;
            msg_cnt_r   <= 32'h00000000;
            cal_fail_r  <= 1'b0;
            sys_alarm_r <= 1'b0;
            cell_fail_r <= 1'b0;
        end else begin
            mode_r    <= mode_nxt;
            msg_cnt_r <= (mode_nxt != mode_r || mode_r == CAS_MEASURE) ? 32'h00000000
                                                                      : msg_cnt_r + 32'h1;
            // Set wins over the standby clear; a good span never clears.
            cal_fail_r  <= span_rej | (cal_fail_r & ~standby_rise);
            cell_fail_r <= zero_bad | (cell_fail_r & ~standby_rise);
            sys_alarm_r <= span_rej | zero_bad | (sys_alarm_r & ~standby_rise);
        end
    end

    // -------------------------------------------------------------------
    // Interrupts and read data
    // -------------------------------------------------------------------
    wire [CAS_IRQ_W-1:0] irq_evt = {zero_bad, span_rej, al_trip};
    assign irq_stat_nxt = irq_evt | (rd_irq ? '0 : irq_stat_r);

    logic [31:0] rd_mux;
    always_comb begin
        unique case (ADDR_IN)
            CAS_OFF_CTRL:     rd_mux = {29'h0, ctrl_r[2], unlocked_r, ctrl_r[0]};
            CAS_OFF_A1_CFG:   rd_mux = {28'h0, a1_cfg_r};
            CAS_OFF_A1_SET:   rd_mux = {12'h0, a1_set_r};
            CAS_OFF_A2_CFG:   rd_mux = {28'h0, a2_cfg_r};
            CAS_OFF_A2_SET:   rd_mux = {12'h0, a2_set_r};
            CAS_OFF_CONC:     rd_mux = {12'h0, conc_r};
            CAS_OFF_STATUS:   rd_mux = {24'h0, mode_r, cell_fail_r, sys_alarm_r,
                                        cal_fail_r, al_active};
            CAS_OFF_IRQ_STAT: rd_mux = {28'h0, irq_stat_r};
            CAS_OFF_IRQ_MASK: rd_mux = {28'h0, irq_mask_r};
            CAS_OFF_CAL:      rd_mux = cal_val;
            default:          rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_r        <= '0;
            RDATA_OUT         <= 32'h00000000;
            IRQ_OUT           <= 1'b0;
            RELAY_ONE_OUT     <= 1'b0;
            RELAY_TWO_OUT     <= 1'b0;
            RELAY_SYS_OUT     <= 1'b0;
            CAL_FAIL_FLAG_OUT <= 1'b0;
            SPAN_MSG_OUT      <= 1'b0;
            CELL_MSG_OUT      <= 1'b0;
        end else begin
            irq_stat_r        <= irq_stat_nxt;
            RDATA_OUT         <= RD_IN ? rd_mux : 32'h00000000;
            IRQ_OUT           <= |(irq_stat_nxt & irq_mask_r);
            RELAY_ONE_OUT     <= al_relay[0];
            RELAY_TWO_OUT     <= al_relay[1];
            // System relay is failsafe: energized while healthy.
            RELAY_SYS_OUT     <= ~sys_alarm_r;
            CAL_FAIL_FLAG_OUT <= cal_fail_r;
            SPAN_MSG_OUT      <= mode_r == CAS_SPANMSG;
            CELL_MSG_OUT      <= cell_fail_r;
        end
    end
endmodule : cas_conc_alarm_top

// ---- cas_chk.sv ----
// Port-level checker for the alarm and span block.
// Assumes it is bound into the top module and sees only its ports.
module cas_chk
    import cas_pkg::*;
#(
    parameter longint MSG_CYCLES = CAS_MSG_CYCLES
) (
    input wire logic        CLK_SYS_IN,
    input wire logic        ARST_N_IN,
    input wire logic [7:0]  ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic        WR_IN,
    input wire logic        RELAY_ONE_OUT,
    input wire logic        RELAY_TWO_OUT,
    input wire logic        RELAY_SYS_OUT,
    input wire logic        CAL_FAIL_FLAG_OUT,
    input wire logic        SPAN_MSG_OUT,
    input wire logic        CELL_MSG_OUT
);
    timeunit 1ns;
    timeprecision 100ps;
    // -------------------------------------------------------------------
    // Span message length and ages since the last write, standby request and reset release
    // -------------------------------------------------------------------
    logic [31:0] msg_cnt_r;
    logic [2:0]  wr_age_r;
    logic [2:0]  sb_age_r;
    logic [2:0]  rst_age_r;
    wire         span_wr = WR_IN && ADDR_IN == CAS_OFF_SPAN;
    wire         sb_wr   = WR_IN && ADDR_IN == CAS_OFF_CTRL && WDATA_IN[CAS_CTRL_STANDBY];

    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            msg_cnt_r <= 32'h0;
            wr_age_r  <= 3'h7;
            sb_age_r  <= 3'h7;
            rst_age_r <= 3'h0;
        end else begin
            msg_cnt_r <= SPAN_MSG_OUT ? msg_cnt_r + 32'h1 : 32'h0;
            wr_age_r  <= WR_IN ? 3'h0 : wr_age_r + {2'h0, wr_age_r != 3'h7};
            sb_age_r  <= sb_wr ? 3'h0 : sb_age_r + {2'h0, sb_age_r != 3'h7};
            rst_age_r <= rst_age_r + {2'h0, rst_age_r != 3'h7};
        end
    end

    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    sequence s_span_bad;
        span_wr && WDATA_IN[0] && WDATA_IN[31:16] < CAS_SENS_MIN;
    endsequence
    sequence s_span_good;
        span_wr && WDATA_IN[0] && WDATA_IN[31:16] >= CAS_SENS_MIN;
    endsequence
    property p_span_rej;
        s_span_bad |-> ##2 (CAL_FAIL_FLAG_OUT && SPAN_MSG_OUT && !RELAY_SYS_OUT);
    endproperty
    a_span_rej: assert property (p_span_rej) else $error("span reject not shown");
    property p_good_keep;
        CAL_FAIL_FLAG_OUT ##0 s_span_good |-> ##2 (CAL_FAIL_FLAG_OUT && !RELAY_SYS_OUT);
    endproperty
    a_good_keep: assert property (p_good_keep) else $error("good span cleared fail");
    property p_msg_len;
        $fell(SPAN_MSG_OUT) |-> msg_cnt_r == MSG_CYCLES;
    endproperty
    a_msg_len: assert property (p_msg_len) else $error("span message length");
    property p_msg_start;
        $rose(SPAN_MSG_OUT) |-> CAL_FAIL_FLAG_OUT && !RELAY_SYS_OUT;
    endproperty
    a_msg_start: assert property (p_msg_start) else $error("message without alarm");
    property p_fail_hold;
        $fell(CAL_FAIL_FLAG_OUT) |-> sb_age_r <= 3'h4;
    endproperty
    a_fail_hold: assert property (p_fail_hold) else $error("fail flag cleared early");
    property p_sys_hold;
        $rose(RELAY_SYS_OUT) |-> sb_age_r <= 3'h4 || rst_age_r < 3'h6;
    endproperty
    a_sys_hold: assert property (p_sys_hold) else $error("system alarm cleared early");
    property p_cell;
        span_wr && WDATA_IN[CAS_SPAN_ZERO_BAD] |-> ##[1:3] (CELL_MSG_OUT && !RELAY_SYS_OUT);
    endproperty
    a_cell: assert property (p_cell) else $error("cell failure not shown");
    property p_relay;
        ($changed(RELAY_ONE_OUT) || $changed(RELAY_TWO_OUT)) && rst_age_r > 3'h5
            |-> wr_age_r <= 3'h4;
    endproperty
    a_relay: assert property (p_relay) else $error("relay moved without cause");
endmodule : cas_chk

bind cas_conc_alarm_top cas_chk #(.MSG_CYCLES(MSG_CYCLES)) u_cas_chk (
    .CLK_SYS_IN(CLK_SYS_IN), .ARST_N_IN(ARST_N_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RELAY_ONE_OUT(RELAY_ONE_OUT),
    .RELAY_TWO_OUT(RELAY_TWO_OUT), .RELAY_SYS_OUT(RELAY_SYS_OUT),
    .CAL_FAIL_FLAG_OUT(CAL_FAIL_FLAG_OUT), .SPAN_MSG_OUT(SPAN_MSG_OUT),
    .CELL_MSG_OUT(CELL_MSG_OUT)
);

// ---- cas_panel_model.sv ----
// Front-panel operator model that drives the register port.
// Assumes the block samples strobes on the rising clock edge.
module cas_panel_model (
    input  wire logic        clk_in,
    input  wire logic [31:0] rdata_in,
    output logic      [7:0]  addr_out,
    output logic      [31:0] wdata_out,
    output logic             wr_out,
    output logic             rd_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        addr_out  = 8'h00;
        wdata_out = 32'h0;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
    end
    // Idle address and data show the inverse of the last value.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge clk_in);
        wr_out    <= 1'b0;
        addr_out  <= ~a;
        wdata_out <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge clk_in);
        rd_out   <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
    endtask : rd
    // Operator clears a latched alarm by toggling defeat or latching.
    task automatic unlatch(input logic [7:0] a, input logic [3:0] c, input logic by_latch);
        wr(a, {28'h0, by_latch ? (c & 4'h7) : (c | 4'h2)});
        wr(a, {28'h0, c});
    endtask : unlatch
endmodule : cas_panel_model

// ---- cas_conc_alarm_top_test.sv ----
// Self-checking bench for the alarm and span block.
// Assumes the operator model drives the register port.
module cas_conc_alarm_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    import cas_pkg::*;
    localparam longint MSG = 20;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, rv;
    logic        wr, rd, r1, r2, rs, cf, sm, cm, irq;
    int          n_fail = 0;
    int          check_count = 0;

    always #2.5 clk = ~clk;

    cas_panel_model op (.clk_in(clk), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
    cas_conc_alarm_top #(.MSG_CYCLES(MSG)) uut (.CLK_SYS_IN(clk), .ARST_N_IN(rst_n),
        .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .RELAY_ONE_OUT(r1), .RELAY_TWO_OUT(r2), .RELAY_SYS_OUT(rs),
        .CAL_FAIL_FLAG_OUT(cf), .SPAN_MSG_OUT(sm), .CELL_MSG_OUT(cm), .IRQ_OUT(irq));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic conc(input logic [19:0] c, input logic e1, input logic e2);
        op.wr(CAS_OFF_CONC, {12'h0, c});
        tick(2);
        check("relay_one", 32'(r1), 32'(e1));
        check("relay_two", 32'(r2), 32'(e2));
    endtask : conc
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        op.rd(a, rv);
        check("rdata", rv, exp);
    endtask : rdchk
    task automatic standby;
        op.wr(CAS_OFF_CTRL, 32'h4);
        op.wr(CAS_OFF_CTRL, 32'h0);
        tick(2);
    endtask : standby
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        test_done();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        tick(3);
        check("relay_sys", 32'(rs), 32'h1);
        op.wr(CAS_OFF_A1_CFG, 32'h1);
        op.wr(CAS_OFF_A1_SET, 32'd1000);
        op.wr(CAS_OFF_A2_CFG, 32'h4);
        op.wr(CAS_OFF_A2_SET, 32'd500);
        conc(20'd1000, 1'b0, 1'b1);
        conc(20'd1001, 1'b1, 1'b1);
        conc(20'd499, 1'b0, 1'b0);
        conc(20'd500, 1'b0, 1'b1);
        $display("test directions done");
        op.wr(CAS_OFF_A1_CFG, 32'h9);
        conc(20'd1001, 1'b1, 1'b1);
        conc(20'd999, 1'b1, 1'b1);
        op.unlatch(CAS_OFF_A1_CFG, 4'h9, 1'b0);
        conc(20'd999, 1'b0, 1'b1);
        conc(20'd1001, 1'b1, 1'b1);
        op.unlatch(CAS_OFF_A1_CFG, 4'h9, 1'b1);
        conc(20'd999, 1'b0, 1'b1);
        $display("test latching done");
        op.wr(CAS_OFF_A1_CFG, 32'h3);
        conc(20'd5000, 1'b0, 1'b1);
        op.wr(CAS_OFF_A1_CFG, 32'h7);
        conc(20'd5000, 1'b1, 1'b1);
        op.wr(CAS_OFF_A1_CFG, 32'h1);
        op.wr(CAS_OFF_A1_SET, 32'd1000000);
        conc(20'd1000000, 1'b0, 1'b1);
        conc(20'd1000001, 1'b1, 1'b1);
        op.wr(CAS_OFF_A1_SET, 32'd1000001);
        conc(20'd1000001, 1'b1, 1'b1);
        $display("test defeat and range done");
        op.wr(CAS_OFF_CTRL, 32'h1);
        op.wr(CAS_OFF_A1_CFG, 32'h0);
        conc(20'd5, 1'b0, 1'b0);
        op.wr(CAS_OFF_PASSWORD, CAS_PASSWORD_DEF);
        op.wr(CAS_OFF_A1_CFG, 32'h0);
        conc(20'd5, 1'b1, 1'b0);
        op.wr(CAS_OFF_CTRL, 32'h0);
        $display("test password done");
        op.wr(CAS_OFF_A2_CFG, 32'h2);
        op.wr(CAS_OFF_A1_CFG, 32'h1);
        op.wr(CAS_OFF_A1_SET, 32'd1000);
        op.wr(CAS_OFF_IRQ_MASK, 32'h0);
        conc(20'd999, 1'b0, 1'b0);
        op.rd(CAS_OFF_IRQ_STAT, rv);
        conc(20'd1001, 1'b1, 1'b0);
        check("irq", 32'(irq), 32'h0);
        rdchk(CAS_OFF_IRQ_STAT, 32'h1);
        op.wr(CAS_OFF_IRQ_MASK, 32'h1);
        conc(20'd999, 1'b0, 1'b0);
        conc(20'd1001, 1'b1, 1'b0);
        tick(2);
        check("irq", 32'(irq), 32'h1);
        rdchk(CAS_OFF_IRQ_STAT, 32'h1);
        tick(2);
        check("irq", 32'(irq), 32'h0);
        rdchk(8'h3c, 32'h0);
        $display("test interrupt done");
        op.wr(CAS_OFF_CAL, 32'h11);
        op.wr(CAS_OFF_SPAN, 32'h01f40001);
        rdchk(CAS_OFF_CAL, 32'h11);
        op.wr(CAS_OFF_CAL, 32'h22);
        op.wr(CAS_OFF_SPAN, 32'h01f30001);
        tick(2);
        check("cal_fail", 32'(cf), 32'h1);
        check("relay_sys", 32'(rs), 32'h0);
        check("span_msg", 32'(sm), 32'h1);
        tick(18);
        check("span_msg", 32'(sm), 32'h1);
        tick(1);
        check("span_msg", 32'(sm), 32'h0);
        rdchk(CAS_OFF_CAL, 32'h11);
        op.rd(CAS_OFF_STATUS, rv);
        check("status", {26'h0, rv[7:2]}, {26'h0, CAS_MEASURE, 3'b011});
        op.wr(CAS_OFF_SPAN, 32'h01f40001);
        tick(2);
        check("cal_fail", 32'(cf), 32'h1);
        check("relay_sys", 32'(rs), 32'h0);
        standby();
        check("cal_fail", 32'(cf), 32'h0);
        check("relay_sys", 32'(rs), 32'h1);
        $display("test span done");
        op.wr(CAS_OFF_SPAN, 32'h2);
        tick(2);
        check("cell_msg", 32'(cm), 32'h1);
        check("relay_sys", 32'(rs), 32'h0);
        standby();
        check("cell_msg", 32'(cm), 32'h0);
        check("relay_sys", 32'(rs), 32'h1);
        $display("test cell done");
        test_done();
    end
endmodule : cas_conc_alarm_top_test
